/* File: design/fpec_defines.vh */
// Constants for the flash program and erase control block
`ifndef FPEC_DEFINES_VH
`define FPEC_DEFINES_VH

// Register select codes on the processor write/read port
`define FPEC_SEL_OP_CONTROL    3'h0
`define FPEC_SEL_UNLOCK_KEY    3'h1
`define FPEC_SEL_ADDR_LOW      3'h2
`define FPEC_SEL_ADDR_HIGH     3'h3
`define FPEC_SEL_SRC_LOW       3'h4
`define FPEC_SEL_SRC_HIGH      3'h5

// Operation control field layout
`define FPEC_START_BIT         15
`define FPEC_OP_MSB            3
`define FPEC_OP_LSB            0

// Operation codes
`define FPEC_OP_WORD_PAIR      4'h1
`define FPEC_OP_ROW            4'h2
`define FPEC_OP_PAGE_ERASE     4'h3

// Unlock key values
`define FPEC_KEY_FIRST         8'h55
`define FPEC_KEY_SECOND        8'haa

// Alignment of the effective address (address units, two per instruction)
`define FPEC_PAGE_ALIGN_BITS   10
`define FPEC_ROW_ALIGN_BITS    7
`define FPEC_PAIR_ALIGN_BITS   2

// Reset values
`define FPEC_RST_CONTROL       16'h0000
`define FPEC_RST_ADDR_LOW      16'h0000
`define FPEC_RST_ADDR_HIGH     8'h00
`define FPEC_RST_SRC_LOW       16'h0000
`define FPEC_RST_SRC_HIGH      8'h00

`endif

/* File: design/fpec_unlock.v */
// Two-write unlock key sequence detector
`timescale 1ns/1ps
`default_nettype none
`include "fpec_defines.vh"

module fpec_unlock (
    input  wire       sys_clk_i,
    input  wire       resetn_i,
    input  wire       wr_i,
    input  wire       key_sel_i,
    input  wire       start_try_i,
    input  wire [7:0] key_data_i,
    output wire       armed_o
);

    localparam [1:0] ST_LOCKED = 2'h0;
    localparam [1:0] ST_FIRST  = 2'h1;
    localparam [1:0] ST_ARMED  = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;

    ////////////////////////////////////////////////////////////////////////////
    always @* begin
        state_d = state_q;
        if (start_try_i) begin
            state_d = ST_LOCKED;
        end else if (wr_i) begin
            if (!key_sel_i) begin
                // Any other write breaks the sequence
                state_d = ST_LOCKED;
            end else begin
                case (state_q)
                    ST_LOCKED: state_d = (key_data_i == `FPEC_KEY_FIRST) ? ST_FIRST : ST_LOCKED;
                    ST_FIRST: begin
                        if (key_data_i == `FPEC_KEY_SECOND) begin
                            state_d = ST_ARMED;
                        end else if (key_data_i == `FPEC_KEY_FIRST) begin
                            state_d = ST_FIRST;
                        end else begin
                            state_d = ST_LOCKED;
                        end
                    end
                    ST_ARMED: state_d = (key_data_i == `FPEC_KEY_FIRST) ? ST_FIRST : ST_LOCKED;
                    default: state_d = ST_LOCKED;
                endcase
            end
        end
    end

    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_LOCKED;
        end else begin
            state_q <= state_d;
        end
    end

    assign armed_o = (state_q == ST_ARMED);

endmodule
`default_nettype wire

/* File: design/fpec_top.v */
// Flash program and erase control front end
//
// What this block does
// - Control register picks operation type and holds the start bit.
// - Unlock key register is write-only; reads give zero.
// - High and low address registers join into a 24-bit effective address.
// - High address holds upper 8 bits, low address the lower 16.
// - Source address pair holds the data-memory address for row data.
// - Bit 15 starts the operation; hardware clears it on completion.
// - Processor is stalled while an operation runs.
// - Rows are 64 instructions, pages eight rows, both boundary aligned.
`timescale 1ns/1ps
`default_nettype none
`include "fpec_defines.vh"

module fpec_top (
    input  wire        sys_clk_i,
    input  wire        resetn_i,
    // Processor register port
    input  wire        reg_wr_i,
    input  wire [2:0]  reg_sel_i,
    input  wire [15:0] reg_wdata_i,
    output reg  [15:0] reg_rdata_o,
    // Processor hold
    output wire        cpu_stall_o,
    // Flash array side
    output reg         flash_op_start_o,
    output reg  [3:0]  flash_op_code_o,
    output reg  [23:0] flash_target_addr_o,
    output reg  [23:0] flash_src_addr_o,
    input  wire        flash_op_done_i,
    output wire        flash_busy_o
);

    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    reg        state_q;
    reg [15:0] op_control_q;
    reg [15:0] addr_low_q;
    reg [7:0]  addr_high_q;
    reg [15:0] src_low_q;
    reg [7:0]  src_high_q;

    wire       armed;
    wire       ctrl_wr;
    wire       start_try;
    wire       op_valid;
    wire [3:0] op_req;
    wire [23:0] eff_addr;

    ////////////////////////////////////////////////////////////////////////////
    // Clear the low address bits below the page or row boundary; word pair addresses pass through unchanged
    function [23:0] align_addr;
        input [23:0] addr;
        input [3:0]  op;
        begin
            case (op)
                `FPEC_OP_PAGE_ERASE:
                    align_addr = {addr[23:`FPEC_PAGE_ALIGN_BITS],
                                  {`FPEC_PAGE_ALIGN_BITS{1'b0}}};
                `FPEC_OP_ROW:
                    align_addr = {addr[23:`FPEC_ROW_ALIGN_BITS],
                                  {`FPEC_ROW_ALIGN_BITS{1'b0}}};
                default:
                    align_addr = addr;
            endcase
        end
    endfunction

    function is_valid_op;
        input [3:0] op;
        begin
            is_valid_op = (op == `FPEC_OP_WORD_PAIR) || (op == `FPEC_OP_ROW) ||
                          (op == `FPEC_OP_PAGE_ERASE);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Writes other than the key are ignored while busy; the core is held then
    assign ctrl_wr   = reg_wr_i && (reg_sel_i == `FPEC_SEL_OP_CONTROL) && (state_q == ST_IDLE);
    assign start_try = ctrl_wr && reg_wdata_i[`FPEC_START_BIT];
    assign op_req    = reg_wdata_i[`FPEC_OP_MSB:`FPEC_OP_LSB];
    assign op_valid  = is_valid_op(op_req);
    assign eff_addr  = {addr_high_q, addr_low_q};

    fpec_unlock u_unlock (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .wr_i        (reg_wr_i),
        .key_sel_i   (reg_sel_i == `FPEC_SEL_UNLOCK_KEY),
        .start_try_i (start_try),
        .key_data_i  (reg_wdata_i[7:0]),
        .armed_o     (armed)
    );

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q             <= ST_IDLE;
            op_control_q        <= `FPEC_RST_CONTROL;
            addr_low_q          <= `FPEC_RST_ADDR_LOW;
            addr_high_q         <= `FPEC_RST_ADDR_HIGH;
            src_low_q           <= `FPEC_RST_SRC_LOW;
            src_high_q          <= `FPEC_RST_SRC_HIGH;
            flash_op_start_o    <= 1'b0;
            flash_op_code_o     <= 4'h0;
            flash_target_addr_o <= 24'h000000;
            flash_src_addr_o    <= 24'h000000;
        end else begin
            flash_op_start_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (reg_wr_i) begin
                        case (reg_sel_i)
                            `FPEC_SEL_OP_CONTROL: begin
                                op_control_q <= {1'b0, reg_wdata_i[14:0]};
                                if (start_try && armed && op_valid) begin
                                    op_control_q[`FPEC_START_BIT] <= 1'b1;
                                    state_q             <= ST_BUSY;
                                    flash_op_start_o    <= 1'b1;
                                    flash_op_code_o     <= op_req;
                                    flash_target_addr_o <= align_addr(eff_addr, op_req);
                                    flash_src_addr_o    <= {src_high_q, src_low_q};
                                end
                            end
                            `FPEC_SEL_ADDR_LOW:  addr_low_q  <= reg_wdata_i;
                            `FPEC_SEL_ADDR_HIGH: addr_high_q <= reg_wdata_i[7:0];
                            `FPEC_SEL_SRC_LOW:   src_low_q   <= reg_wdata_i;
                            `FPEC_SEL_SRC_HIGH:  src_high_q  <= reg_wdata_i[7:0];
                            default: ;
                        endcase
                    end
                end
                ST_BUSY: begin
                    if (flash_op_done_i) begin
                        op_control_q[`FPEC_START_BIT] <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 16'h0000;
        end else begin
            case (reg_sel_i)
                `FPEC_SEL_OP_CONTROL: reg_rdata_o <= op_control_q;
                `FPEC_SEL_UNLOCK_KEY: reg_rdata_o <= 16'h0000;
                `FPEC_SEL_ADDR_LOW:   reg_rdata_o <= addr_low_q;
                `FPEC_SEL_ADDR_HIGH:  reg_rdata_o <= {8'h00, addr_high_q};
                `FPEC_SEL_SRC_LOW:    reg_rdata_o <= src_low_q;
                `FPEC_SEL_SRC_HIGH:   reg_rdata_o <= {8'h00, src_high_q};
                default:              reg_rdata_o <= 16'h0000;
            endcase
        end
    end

    assign cpu_stall_o  = (state_q == ST_BUSY);
    assign flash_busy_o = (state_q == ST_BUSY);

endmodule
`default_nettype wire

/* File: dv/fpec_props.sv */
// Port-level property checker for the flash program and erase control
`timescale 1ns/1ps
`default_nettype none
module fpec_props (
    input wire logic        sys_clk_i,
    input wire logic        resetn_i,
    input wire logic        reg_wr_i,
    input wire logic [2:0]  reg_sel_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        cpu_stall_o,
    input wire logic        flash_op_start_o,
    input wire logic [3:0]  flash_op_code_o,
    input wire logic [23:0] flash_target_addr_o,
    input wire logic        flash_op_done_i,
    input wire logic        flash_busy_o
);
    wire k55 = reg_wr_i && reg_sel_i == 3'h1 && reg_wdata_i[7:0] == 8'h55;
    wire kaa = reg_wr_i && reg_sel_i == 3'h1 && reg_wdata_i[7:0] == 8'haa;
    wire go  = reg_wr_i && reg_sel_i == 3'h0 && reg_wdata_i[15];
    wire opv = reg_wdata_i[3:0] != 4'h0 && reg_wdata_i[3:0] < 4'h4;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////
    // Non-key writes while busy are dropped, so only an idle go counts
    sequence unlock_go;
        k55 ##1 kaa ##1 (go && opv && !cpu_stall_o);
    endsequence
    chk_unlock_start: assert property (unlock_go |=> flash_op_start_o)
        else $error("start missing after unlock");
    chk_start_cause: assert property (flash_op_start_o |->
        $past(go) && $past(kaa, 2) && $past(k55, 3)) else $error("start without key");
    chk_start_pulse: assert property (flash_op_start_o |=> !flash_op_start_o)
        else $error("start pulse too long");
    chk_stall_rise: assert property (flash_op_start_o |-> cpu_stall_o && !$past(cpu_stall_o))
        else $error("stall not raised with start");
    chk_stall_hold: assert property (cpu_stall_o && !flash_op_done_i |=> cpu_stall_o)
        else $error("stall dropped early");
    chk_stall_end: assert property (cpu_stall_o && flash_op_done_i |=> !cpu_stall_o)
        else $error("stall kept after done");
    chk_busy_same: assert property (flash_busy_o == cpu_stall_o)
        else $error("busy and stall differ");
    chk_op_valid: assert property (flash_op_start_o |-> flash_op_code_o inside {[4'h1:4'h3]})
        else $error("bad op code");
    chk_page_align: assert property (flash_op_start_o && flash_op_code_o == 4'h3 |->
        flash_target_addr_o[9:0] == 10'h000) else $error("page not aligned");
    chk_row_align: assert property (flash_op_start_o && flash_op_code_o == 4'h2 |->
        flash_target_addr_o[6:0] == 7'h00) else $error("row not aligned");
    chk_key_hidden: assert property ($past(reg_sel_i) == 3'h1 |-> reg_rdata_o == 16'h0000)
        else $error("key readable");
endmodule
bind fpec_top fpec_props u_props (.sys_clk_i, .resetn_i, .reg_wr_i, .reg_sel_i, .reg_wdata_i,
    .reg_rdata_o, .cpu_stall_o, .flash_op_start_o, .flash_op_code_o, .flash_target_addr_o,
    .flash_op_done_i, .flash_busy_o);
`default_nettype wire

/* File: dv/fpec_top_tb.sv */
// Self-checking bench for the flash program and erase control
`timescale 1ns/1ps
`default_nettype none
module fpec_top_tb;
    logic        sys_clk_i, resetn_i, reg_wr_i, flash_op_done_i;
    logic [2:0]  reg_sel_i;
    logic [15:0] reg_wdata_i;
    wire  [15:0] reg_rdata_o;
    wire         cpu_stall_o, flash_op_start_o, flash_busy_o;
    wire  [3:0]  flash_op_code_o;
    wire  [23:0] flash_target_addr_o, flash_src_addr_o;
    int          fails, n_compared;
    fpec_top u_dut (.sys_clk_i, .resetn_i, .reg_wr_i, .reg_sel_i, .reg_wdata_i, .reg_rdata_o,
        .cpu_stall_o, .flash_op_start_o, .flash_op_code_o, .flash_target_addr_o,
        .flash_src_addr_o, .flash_op_done_i, .flash_busy_o);
    ////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Strobe stays up so back-to-back writes never retoggle it in one step
    task wr(input logic [2:0] s, input logic [15:0] d);
        reg_wr_i = 1'b1;
        reg_sel_i = s;
        reg_wdata_i = d;
        @(posedge sys_clk_i);
        #10;
    endtask
    task rd(input logic [2:0] s, input logic [15:0] exp);
        reg_sel_i = s;
        @(posedge sys_clk_i);
        #10;
        chk("read data", {8'h00, reg_rdata_o}, {8'h00, exp});
    endtask
    task finish_op;
        flash_op_done_i = 1'b1;
        @(posedge sys_clk_i);
        #10;
        flash_op_done_i = 1'b0;
        chk("stall", cpu_stall_o, 24'h0);
    endtask
    ////////////////////////////////////////////////////////////
    task run_op(input logic [3:0] op, input logic [15:0] lo, input logic [23:0] ea);
        wr(3'h3, 16'h005a);
        wr(3'h2, lo);
        wr(3'h4, 16'h1234);
        wr(3'h5, 16'h0077);
        wr(3'h1, 16'h0055);
        wr(3'h1, 16'h00aa);
        wr(3'h0, {12'h800, op});
        reg_wr_i = 1'b0;
        chk("start", flash_op_start_o, 24'h1);
        chk("op code", flash_op_code_o, {20'h0, op});
        chk("target", flash_target_addr_o, ea);
        chk("source", flash_src_addr_o, 24'h771234);
        rd(3'h0, {12'h800, op});
        chk("start", flash_op_start_o, 24'h0);
        chk("stall", cpu_stall_o, 24'h1);
        chk("busy", flash_busy_o, 24'h1);
        wr(3'h2, 16'h0000);
        reg_wr_i = 1'b0;
        finish_op;
        chk("busy", flash_busy_o, 24'h0);
        rd(3'h0, {12'h000, op});
        rd(3'h2, lo);
        rd(3'h3, 16'h005a);
        rd(3'h4, 16'h1234);
        rd(3'h5, 16'h0077);
    endtask
    // A reset in mid-operation must drop the stall and relock the key
    task mid_reset;
        wr(3'h1, 16'h0055);
        wr(3'h1, 16'h00aa);
        wr(3'h0, 16'h8002);
        reg_wr_i = 1'b0;
        chk("stall", cpu_stall_o, 24'h1);
        resetn_i = 1'b0;
        @(posedge sys_clk_i);
        #10;
        resetn_i = 1'b1;
        chk("stall", cpu_stall_o, 24'h0);
        chk("busy", flash_busy_o, 24'h0);
        rd(3'h2, 16'h0000);
        wr(3'h0, 16'h8002);
        reg_wr_i = 1'b0;
        chk("start", flash_op_start_o, 24'h0);
        rd(3'h0, 16'h0002);
    endtask
    task refuse;
        wr(3'h1, 16'h0055);
        wr(3'h2, 16'hb3fa);
        wr(3'h1, 16'h00aa);
        wr(3'h0, 16'h8003);
        reg_wr_i = 1'b0;
        chk("start", flash_op_start_o, 24'h0);
        rd(3'h0, 16'h0003);
        wr(3'h1, 16'h0055);
        wr(3'h1, 16'h00aa);
        wr(3'h0, 16'h8007);
        wr(3'h0, 16'h8003);
        reg_wr_i = 1'b0;
        chk("stall", cpu_stall_o, 24'h0);
        rd(3'h1, 16'h0000);
        rd(3'h7, 16'h0000);
    endtask
    task key_repeat;
        wr(3'h1, 16'h0055);
        wr(3'h1, 16'h0055);
        wr(3'h1, 16'h00aa);
        wr(3'h0, 16'h8001);
        reg_wr_i = 1'b0;
        chk("start", flash_op_start_o, 24'h1);
        chk("target", flash_target_addr_o, 24'h5ab3fa);
        finish_op;
    endtask
    task close_out;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #100000;
        fails++;
        close_out;
    end
    initial begin
        resetn_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_sel_i = 3'h0;
        reg_wdata_i = 16'h0000;
        flash_op_done_i = 1'b0;
        fails = 0;
        n_compared = 0;
        repeat (4) @(posedge sys_clk_i);
        #10;
        resetn_i = 1'b1;
        chk("stall", cpu_stall_o, 24'h0);
        rd(3'h0, 16'h0000);
        // Page erased first, pair target passed through without alignment
        run_op(4'h3, 16'hb3fa, 24'h5ab000);
        run_op(4'h2, 16'hb3fa, 24'h5ab380);
        run_op(4'h1, 16'hb3fa, 24'h5ab3fa);
        refuse;
        key_repeat;
        mid_reset;
        close_out;
    end
endmodule
`default_nettype wire
